/* File: hdl/lhg_params.svh */
/*
  Offsets, field positions, reset values and timing counts of the line
  heat guard. Assumes a register file of 32-bit words at byte addresses.
*/
`ifndef LHG_PARAMS_SVH
`define LHG_PARAMS_SVH

// timing
`define LHG_CLK_HZ        40000000
`define LHG_CALC_HZ       1000
`define LHG_SEC_PER_MIN   60
`define LHG_DIV_STEPS     7'h40

// register byte offsets
`define LHG_A_CTRL        8'h00
`define LHG_A_ALARM       8'h04
`define LHG_A_TRIP        8'h08
`define LHG_A_UNLOCK      8'h0C
`define LHG_A_RATED       8'h10
`define LHG_A_BASE        8'h14
`define LHG_A_AMBIENT     8'h18
`define LHG_A_STARTUP     8'h1C
`define LHG_A_LOAD        8'h20
`define LHG_A_TCONST      8'h28
`define LHG_A_STATUS      8'h2C
`define LHG_A_TEMP        8'h30
`define LHG_A_HEAT        8'h34
`define LHG_A_IRQ_STS     8'h38
`define LHG_A_IRQ_MASK    8'h3C

// field positions
`define LHG_F_OP_LO       0
`define LHG_F_OP_HI       1
`define LHG_F_SENSOR      2
`define LHG_F_ALARM       0
`define LHG_F_TRIP        1
`define LHG_F_UNLOCK      2

// reset values
`define LHG_R_ALARM       8'h50
`define LHG_R_TRIP        8'h64
`define LHG_R_UNLOCK      8'h3C
`define LHG_R_RATED       8'h64
`define LHG_R_BASE        8'h19
`define LHG_R_AMBIENT     8'h19
`define LHG_R_STARTUP     8'h00
`define LHG_R_LOAD        8'h64
`define LHG_R_TCONST      10'h00A

// scaling
`define LHG_PCT_FULL      8'h64
`define LHG_PCT_SQ        14'h2710

`endif

/* File: hdl/lhg_pkg.sv */
/*
  Types of the line heat guard. Assumes lhg_params.svh for constants.
*/
package lhg_pkg;

  typedef enum logic [1:0] {
    LHG_OP_OFF,
    LHG_OP_PULSED,
    LHG_OP_LATCHED
  } lhg_op_t;

  typedef enum logic [1:0] {
    LHG_ST_IDLE,
    LHG_ST_INIT,
    LHG_ST_RATIO,
    LHG_ST_STEP
  } lhg_state_t;

endpackage

/* File: hdl/lhg_line_heat_guard.sv */
/*
  Line heat guard: per-phase mean square, max select, thermal replica,
  threshold compare, status outputs, register port and interrupt.
  Assumes phase samples, block and heat reset on clk; ambient sensor
  comes from a pin and is synchronised here.
*/
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "lhg_params.svh"

module lhg_line_heat_guard #(
  parameter int          TICK_CYCLES = `LHG_CLK_HZ / `LHG_CALC_HZ,
  parameter int          RMS_SHIFT   = 5,
  parameter logic [15:0] INOM_CODE   = 16'h1000
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // phase current samples
  input  wire logic [15:0] phase_a,
  input  wire logic [15:0] phase_b,
  input  wire logic [15:0] phase_c,
  // ambient sensor pin, degrees
  input  wire logic [7:0]  ambient_sensor,
  // control from protection logic
  input  wire logic        block_in,
  input  wire logic        heat_reset,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata_q,
  // status
  output logic             alarm_q,
  output logic             trip_q,
  output logic             restart_block_q,
  output logic             irq_q
);

  function automatic logic [30:0] lhg_max(input logic [30:0] a,
                                          input logic [30:0] b);
    lhg_max = (a > b) ? a : b;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // calculation rate tick
  logic [15:0] tick_cnt_q;
  logic        tick_q;
  wire         tick_wrap = (tick_cnt_q == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? 16'h0000 : tick_cnt_q + 16'h0001;
      tick_q     <= tick_wrap;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-phase mean square
  logic [15:0] phase [3];
  logic [30:0] ms_q  [3];
  assign phase[0] = phase_a;
  assign phase[1] = phase_b;
  assign phase[2] = phase_c;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ph
      wire [15:0] mag = phase[gi][15] ? 16'(-phase[gi]) : phase[gi];
      wire [30:0] sq  = 31'(mag) * 31'(mag);
      wire [30:0] ms_d = ms_q[gi] - (ms_q[gi] >> RMS_SHIFT)
                       + (sq >> RMS_SHIFT);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ms_q[gi] <= 31'h0;
        end else if (tick_q) begin
          ms_q[gi] <= ms_d;
        end
      end
    end
  endgenerate

  wire [30:0] max_ms = lhg_max(lhg_max(ms_q[0], ms_q[1]), ms_q[2]);

  //////////////////////////////////////////////////////////////////////////
  // registers
  lhg_pkg::lhg_op_t op_q;
  logic        sensor_sel_q;
  logic [7:0]  alarm_thr_q;
  logic [7:0]  trip_thr_q;
  logic [7:0]  unlock_thr_q;
  logic [7:0]  rated_temp_q;
  logic [7:0]  base_temp_q;
  logic [7:0]  ambient_set_q;
  logic [7:0]  startup_q;
  logic [7:0]  rated_load_q;
  logic [9:0]  tconst_q;
  logic [2:0]  irq_sts_q;
  logic [2:0]  irq_mask_q;

  wire wr_ctrl   = wr_en && (addr == `LHG_A_CTRL);
  wire wr_alarm  = wr_en && (addr == `LHG_A_ALARM);
  wire wr_trip   = wr_en && (addr == `LHG_A_TRIP);
  wire wr_unlock = wr_en && (addr == `LHG_A_UNLOCK);
  wire wr_rated  = wr_en && (addr == `LHG_A_RATED);
  wire wr_base   = wr_en && (addr == `LHG_A_BASE);
  wire wr_amb    = wr_en && (addr == `LHG_A_AMBIENT);
  wire wr_start  = wr_en && (addr == `LHG_A_STARTUP);
  wire wr_load   = wr_en && (addr == `LHG_A_LOAD);
  wire wr_tc     = wr_en && (addr == `LHG_A_TCONST);
  wire wr_sts    = wr_en && (addr == `LHG_A_IRQ_STS);
  wire wr_mask   = wr_en && (addr == `LHG_A_IRQ_MASK);
  wire [1:0] op_w = wdata[`LHG_F_OP_HI:`LHG_F_OP_LO];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q          <= lhg_pkg::LHG_OP_PULSED;
      sensor_sel_q  <= 1'b0;
      alarm_thr_q   <= `LHG_R_ALARM;
      trip_thr_q    <= `LHG_R_TRIP;
      unlock_thr_q  <= `LHG_R_UNLOCK;
      rated_temp_q  <= `LHG_R_RATED;
      base_temp_q   <= `LHG_R_BASE;
      ambient_set_q <= `LHG_R_AMBIENT;
      startup_q     <= `LHG_R_STARTUP;
      rated_load_q  <= `LHG_R_LOAD;
      tconst_q      <= `LHG_R_TCONST;
      irq_mask_q    <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        op_q         <= (op_w == 2'h3) ? op_q : lhg_pkg::lhg_op_t'(op_w);
        sensor_sel_q <= wdata[`LHG_F_SENSOR];
      end
      if (wr_alarm)  alarm_thr_q   <= wdata[7:0];
      if (wr_trip)   trip_thr_q    <= wdata[7:0];
      if (wr_unlock) unlock_thr_q  <= wdata[7:0];
      if (wr_rated)  rated_temp_q  <= wdata[7:0];
      if (wr_base)   base_temp_q   <= wdata[7:0];
      if (wr_amb)    ambient_set_q <= wdata[7:0];
      if (wr_start)  startup_q     <= wdata[7:0];
      if (wr_load)   rated_load_q  <= wdata[7:0];
      if (wr_tc)     tconst_q      <= wdata[9:0];
      if (wr_mask)   irq_mask_q    <= wdata[2:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // divider shared by init, ratio and step
  lhg_pkg::lhg_state_t st_q;
  logic [63:0] num_q;
  logic [63:0] den_q;
  logic [63:0] rem_q;
  logic [63:0] quo_q;
  logic [6:0]  cnt_q;
  logic [47:0] heat_q;
  logic        step_neg_q;
  logic        init_pend_q;
  logic        ms_new_q;

  wire        div_done = (cnt_q == 7'h00);
  wire [64:0] div_sh   = {rem_q, num_q[63]};
  wire        div_ge   = (div_sh >= {1'b0, den_q});
  wire [64:0] div_rem  = div_ge ? div_sh - {1'b0, den_q} : div_sh;

  wire idle     = (st_q == lhg_pkg::LHG_ST_IDLE);
  wire ld_init  = idle && init_pend_q;
  wire ld_ratio = idle && !init_pend_q && ms_new_q;
  wire ld_step  = (st_q == lhg_pkg::LHG_ST_RATIO) && div_done;
  wire fin_step = (st_q == lhg_pkg::LHG_ST_STEP) && div_done;
  wire fin_init = (st_q == lhg_pkg::LHG_ST_INIT) && div_done;

  // ratio = ms * 100^2 / (load% * inom)^2, result Q16
  wire [44:0] ms_scaled = 45'(max_ms) * 45'(`LHG_PCT_SQ);
  wire [15:0] load_sq   = 16'(rated_load_q) * 16'(rated_load_q);
  wire [31:0] inom_sq   = 32'(INOM_CODE) * 32'(INOM_CODE);
  wire [47:0] den_ratio = 48'(load_sq) * 48'(inom_sq);
  wire [31:0] ratio_sat = (|quo_q[63:32]) ? 32'hFFFFFFFF : quo_q[31:0];
  wire [48:0] diff      = {1'b0, ratio_sat, 16'h0000} - {1'b0, heat_q};
  wire [47:0] diff_mag  = diff[48] ? 48'(-diff) : diff[47:0];
  wire [25:0] den_step  = 26'(tconst_q * 26'(`LHG_SEC_PER_MIN *
                          `LHG_CALC_HZ));

  wire [63:0] ld_num = ld_init  ? {24'h0, startup_q, 32'h0} :
                       ld_ratio ? {3'h0, ms_scaled, 16'h0} :
                                  {16'h0, diff_mag};
  wire [63:0] ld_den = ld_init  ? {56'h0, `LHG_PCT_FULL} :
                       ld_ratio ? {16'h0, den_ratio} :
                                  {38'h0, den_step};
  wire        ld_any = ld_init || ld_ratio || ld_step;

  wire [47:0] heat_step = step_neg_q ? heat_q - quo_q[47:0]
                                     : heat_q + quo_q[47:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      num_q <= 64'h0;
      den_q <= 64'h0;
      rem_q <= 64'h0;
      quo_q <= 64'h0;
      cnt_q <= 7'h00;
    end else if (ld_any) begin
      num_q <= ld_num;
      den_q <= ld_den;
      rem_q <= 64'h0;
      quo_q <= 64'h0;
      cnt_q <= `LHG_DIV_STEPS;
    end else if (!div_done) begin
      num_q <= {num_q[62:0], 1'b0};
      rem_q <= div_rem[63:0];
      quo_q <= {quo_q[62:0], div_ge};
      cnt_q <= cnt_q - 7'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // thermal replica sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= lhg_pkg::LHG_ST_IDLE;
      heat_q      <= 48'h0;
      step_neg_q  <= 1'b0;
      init_pend_q <= 1'b1;
      ms_new_q    <= 1'b0;
    end else begin
      init_pend_q <= heat_reset || (init_pend_q && !ld_init);
      ms_new_q    <= tick_q || (ms_new_q && !ld_ratio);
      case (st_q)
        lhg_pkg::LHG_ST_IDLE: begin
          if (ld_init) begin
            st_q <= lhg_pkg::LHG_ST_INIT;
          end else if (ld_ratio) begin
            st_q <= lhg_pkg::LHG_ST_RATIO;
          end
        end
        lhg_pkg::LHG_ST_INIT: begin
          if (fin_init) begin
            heat_q <= quo_q[47:0];
            st_q   <= lhg_pkg::LHG_ST_IDLE;
          end
        end
        lhg_pkg::LHG_ST_RATIO: begin
          if (ld_step) begin
            step_neg_q <= diff[48];
            st_q       <= lhg_pkg::LHG_ST_STEP;
          end
        end
        lhg_pkg::LHG_ST_STEP: begin
          if (fin_step) begin
            heat_q <= heat_step;
            st_q   <= lhg_pkg::LHG_ST_IDLE;
          end
        end
        default: st_q <= lhg_pkg::LHG_ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // temperature
  logic [7:0]  amb_s1_q;
  logic [7:0]  amb_s2_q;
  logic [15:0] temp_q;

  wire [7:0]  ref_deg  = (rated_temp_q > base_temp_q) ?
                         rated_temp_q - base_temp_q : 8'h00;
  wire [55:0] over_fx  = 56'(heat_q) * 56'(ref_deg);
  wire [15:0] over_deg = (|over_fx[55:48]) ? 16'hFF00 : over_fx[47:32];
  wire [7:0]  amb_deg  = sensor_sel_q ? amb_s2_q : ambient_set_q;
  wire [15:0] temp_d   = over_deg + {8'h00, amb_deg};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amb_s1_q <= 8'h00;
      amb_s2_q <= 8'h00;
      temp_q   <= 16'h0000;
    end else begin
      amb_s1_q <= ambient_sensor;
      amb_s2_q <= amb_s1_q;
      temp_q   <= temp_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // threshold compare and status
  logic hold_q;
  logic hot_prev_q;

  wire active  = (op_q != lhg_pkg::LHG_OP_OFF) && !block_in;
  wire latched = (op_q == lhg_pkg::LHG_OP_LATCHED);
  wire hot     = (temp_q > {8'h00, trip_thr_q});
  wire warm    = (temp_q > {8'h00, alarm_thr_q});
  wire cool    = (temp_q < {8'h00, unlock_thr_q});
  wire hold_d  = active && (hot || (hold_q && !cool));
  wire pulse_d = active && hot && !hot_prev_q;
  wire trip_d  = latched ? hold_d : pulse_d;
  wire alarm_d = active && warm;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q          <= 1'b0;
      hot_prev_q      <= 1'b0;
      alarm_q         <= 1'b0;
      trip_q          <= 1'b0;
      restart_block_q <= 1'b0;
    end else begin
      hold_q          <= hold_d;
      hot_prev_q      <= active && hot;
      alarm_q         <= alarm_d;
      trip_q          <= trip_d;
      restart_block_q <= hold_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts
  wire [2:0] irq_ev = {hold_q && !hold_d, trip_d && !trip_q,
                       alarm_d && !alarm_q};
  wire [2:0] irq_sts_d = irq_ev | (irq_sts_q & ~(wr_sts ? wdata[2:0]
                                                       : 3'h0));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_q <= 3'h0;
      irq_q     <= 1'b0;
    end else begin
      irq_sts_q <= irq_sts_d;
      irq_q     <= |(irq_sts_d & irq_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    if (addr == `LHG_A_CTRL) begin
      rd_mux = {29'h0, sensor_sel_q, op_q};
    end else if (addr == `LHG_A_ALARM) begin
      rd_mux = {24'h0, alarm_thr_q};
    end else if (addr == `LHG_A_TRIP) begin
      rd_mux = {24'h0, trip_thr_q};
    end else if (addr == `LHG_A_UNLOCK) begin
      rd_mux = {24'h0, unlock_thr_q};
    end else if (addr == `LHG_A_RATED) begin
      rd_mux = {24'h0, rated_temp_q};
    end else if (addr == `LHG_A_BASE) begin
      rd_mux = {24'h0, base_temp_q};
    end else if (addr == `LHG_A_AMBIENT) begin
      rd_mux = {24'h0, ambient_set_q};
    end else if (addr == `LHG_A_STARTUP) begin
      rd_mux = {24'h0, startup_q};
    end else if (addr == `LHG_A_LOAD) begin
      rd_mux = {24'h0, rated_load_q};
    end else if (addr == `LHG_A_TCONST) begin
      rd_mux = {22'h0, tconst_q};
    end else if (addr == `LHG_A_STATUS) begin
      rd_mux = {29'h0, restart_block_q, trip_q, alarm_q};
    end else if (addr == `LHG_A_TEMP) begin
      rd_mux = {16'h0, temp_q};
    end else if (addr == `LHG_A_HEAT) begin
      rd_mux = heat_q[47:16];
    end else if (addr == `LHG_A_IRQ_STS) begin
      rd_mux = {29'h0, irq_sts_q};
    end else if (addr == `LHG_A_IRQ_MASK) begin
      rd_mux = {29'h0, irq_mask_q};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rd_en ? rd_mux : 32'h0;
    end
  end

endmodule

`default_nettype wire

/* File: verification/lhg_guard_props.sv */
/*
  checker of the line heat guard port behaviour.
  assumes the top module ports and lhg_params.svh offsets.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lhg_params.svh"

module lhg_guard_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // control and register port
  input wire logic        block_in,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  // outputs
  input wire logic [31:0] rdata_q,
  input wire logic        alarm_q,
  input wire logic        trip_q,
  input wire logic        restart_block_q,
  input wire logic        irq_q
);

  ////////////////////////////////////////////////////////////////////////////
  // mirror of the operation selector
  logic       [1:0] op_q;
  logic       [1:0] op_d;
  wire logic        ctrl_wr;
  wire logic        quiet;
  wire logic  [2:0] stat;
  assign ctrl_wr = wr_en && addr == `LHG_A_CTRL;
  assign op_d = (ctrl_wr && wdata[1:0] != 2'h3) ? wdata[1:0] : op_q;
  assign quiet = !alarm_q && !trip_q && !restart_block_q;
  assign stat = {restart_block_q, trip_q, alarm_q};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_q <= 2'h1;
    end else begin
      op_q <= op_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_off_wr;
    ctrl_wr && wdata[1:0] == 2'h0;
  endsequence
  sequence s_settled_quiet;
    ##2 quiet;
  endsequence
  property p_off;
    s_off_wr |-> s_settled_quiet;
  endproperty

  chk_off_quiet: assert property (p_off)
    else $error("outputs active after operation off");
  chk_block_quiet: assert property (block_in |=> quiet)
    else $error("outputs active while blocked");
  chk_trip_pairs: assert property (trip_q |-> restart_block_q)
    else $error("trip without restart block");
  chk_pulse_once: assert property (op_q == lhg_pkg::LHG_OP_PULSED &&
    $past(op_q) == lhg_pkg::LHG_OP_PULSED && trip_q |=> !trip_q)
    else $error("pulsed trip longer than one cycle");
  chk_latch_hold: assert property ($fell(trip_q) &&
    op_q == lhg_pkg::LHG_OP_LATCHED && !$past(block_in) &&
    $past(op_q) == lhg_pkg::LHG_OP_LATCHED |-> !restart_block_q)
    else $error("latched trip cleared above unlock");
  chk_status_read: assert property (rd_en && addr == `LHG_A_STATUS
    |=> rdata_q[2:0] == $past(stat))
    else $error("status read differs from outputs");
  chk_irq_masked: assert property (wr_en && addr == `LHG_A_IRQ_MASK &&
    wdata[2:0] == 3'h0 |-> ##2 !irq_q)
    else $error("interrupt with all masked");
  chk_rdata_idle: assert property (!rd_en |=> rdata_q == 32'h0)
    else $error("read data outside read cycle");
  chk_ctrl_upper: assert property (rd_en && addr == `LHG_A_CTRL
    |=> rdata_q[31:3] == 29'h0)
    else $error("control upper bits not zero");
  chk_unmapped: assert property (rd_en && addr == 8'h24
    |=> rdata_q == 32'h0)
    else $error("unmapped read not zero");

endmodule

bind lhg_line_heat_guard lhg_guard_props lhg_guard_props_inst (
  .clk(clk), .rst_n(rst_n), .block_in(block_in), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
  .alarm_q(alarm_q), .trip_q(trip_q), .restart_block_q(restart_block_q),
  .irq_q(irq_q));

`default_nettype wire

/* File: verification/lhg_front_model.sv */
/*
  front end and protection logic model: phase samples, block, heat reset.
  assumes commands from the bench on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

module lhg_front_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // bench commands
  input  wire logic [15:0] amp,
  input  wire logic [1:0]  phase_sel,
  input  wire logic        blk_req,
  input  wire logic        hr_req,
  // to the guard
  output logic      [15:0] phase_a,
  output logic      [15:0] phase_b,
  output logic      [15:0] phase_c,
  output logic             block_in,
  output logic             heat_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // alternating square wave on the selected phase
  logic [15:0] wave_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_q     <= 16'h0000;
      block_in   <= 1'b0;
      heat_reset <= 1'b0;
    end else begin
      wave_q     <= (wave_q == amp) ? 16'h0000 - amp : amp;
      block_in   <= blk_req;
      heat_reset <= hr_req;
    end
  end
  assign phase_a = (phase_sel == 2'h0) ? wave_q : 16'h0000;
  assign phase_b = (phase_sel == 2'h1) ? wave_q : 16'h0000;
  assign phase_c = (phase_sel == 2'h2) ? wave_q : 16'h0000;

endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
/*
  testbench of the line heat guard: registers, thresholds, modes, heat.
  assumes the front model and a shortened calculation tick.
*/
`timescale 1ns/10ps
`default_nettype none
`include "lhg_params.svh"

module tb_top;
  localparam int TK = 200;
  logic        clk, rst_n, blk_req, hr_req, block_in, heat_reset;
  logic [1:0]  phase_sel;
  logic [15:0] amp, phase_a, phase_b, phase_c;
  logic [7:0]  ambient_sensor, addr;
  logic [31:0] wdata, rdata_q;
  logic        wr_en, rd_en, alarm_q, trip_q, restart_block_q, irq_q;
  int          n_mismatch = 0;
  int          cmp_count = 0;

  ////////////////////////////////////////////////////////////////////////////
  // instances
  lhg_front_model lhg_front_model_inst (.clk(clk), .rst_n(rst_n),
    .amp(amp), .phase_sel(phase_sel), .blk_req(blk_req), .hr_req(hr_req),
    .phase_a(phase_a), .phase_b(phase_b), .phase_c(phase_c),
    .block_in(block_in), .heat_reset(heat_reset));
  lhg_line_heat_guard #(.TICK_CYCLES(TK)) lhg_line_heat_guard_inst (
    .clk(clk), .rst_n(rst_n), .phase_a(phase_a), .phase_b(phase_b),
    .phase_c(phase_c), .ambient_sensor(ambient_sensor),
    .block_in(block_in), .heat_reset(heat_reset), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
    .alarm_q(alarm_q), .trip_q(trip_q), .restart_block_q(restart_block_q),
    .irq_q(irq_q));

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata_q;
  endtask
  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    check(nm, v, e);
  endtask
  task automatic steps(input int n);
    repeat (n * (TK + 150)) @(posedge clk);
    #1;
  endtask
  task automatic outs(input string nm, input logic [2:0] e);
    check(nm, {29'h0, restart_block_q, trip_q, alarm_q}, {29'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    logic [7:0]  a [15] = '{`LHG_A_CTRL, `LHG_A_ALARM, `LHG_A_TRIP,
      `LHG_A_UNLOCK, `LHG_A_RATED, `LHG_A_BASE, `LHG_A_AMBIENT,
      `LHG_A_STARTUP, `LHG_A_LOAD, `LHG_A_TCONST, `LHG_A_STATUS,
      `LHG_A_HEAT, `LHG_A_IRQ_STS, `LHG_A_IRQ_MASK, 8'h24};
    logic [31:0] e [15] = '{32'h1, 32'h50, 32'h64, 32'h3C, 32'h64,
      32'h19, 32'h19, 32'h0, 32'h64, 32'hA, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h0};
    for (int i = 0; i < 15; i++) begin
      rc("reset value", a[i], e[i]);
    end
    wr(`LHG_A_STATUS, 32'h7);
    rc("status ro", `LHG_A_STATUS, 32'h0);
    wr(`LHG_A_CTRL, 32'h3);
    rc("op refused", `LHG_A_CTRL, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_ambient;
    steps(1);
    rc("temp setting", `LHG_A_TEMP, 32'h19);
    wr(`LHG_A_CTRL, 32'h5);
    steps(1);
    rc("temp sensor", `LHG_A_TEMP, 32'h28);
    wr(`LHG_A_CTRL, 32'h1);
    steps(1);
    rc("temp back", `LHG_A_TEMP, 32'h19);
    $display("t_ambient done");
  endtask
  task automatic t_startup;
    wr(`LHG_A_STARTUP, 32'h32);
    @(posedge clk);
    hr_req <= 1'b1;
    @(posedge clk);
    hr_req <= 1'b0;
    steps(1);
    rc("temp startup", `LHG_A_TEMP, 32'h3E);
    wr(`LHG_A_STARTUP, 32'h0);
    @(posedge clk);
    hr_req <= 1'b1;
    @(posedge clk);
    hr_req <= 1'b0;
    steps(1);
    rc("temp reload", `LHG_A_TEMP, 32'h19);
    $display("t_startup done");
  endtask
  task automatic t_pulsed;
    int n;
    n = 0;
    wr(`LHG_A_ALARM, 32'h14);
    steps(1);
    outs("alarm only", 3'b001);
    wr(`LHG_A_TRIP, 32'h14);
    repeat (TK + 150) begin
      @(posedge clk);
      #1;
      n += (trip_q === 1'b1) ? 1 : 0;
    end
    check("trip pulses", n, 32'h1);
    outs("restart set", 3'b101);
    check("irq masked", irq_q, 32'h0);
    rc("irq events", `LHG_A_IRQ_STS, 32'h3);
    wr(`LHG_A_TRIP, 32'hC8);
    wr(`LHG_A_UNLOCK, 32'h1E);
    steps(1);
    outs("unlocked", 3'b001);
    rc("irq unlock", `LHG_A_IRQ_STS, 32'h7);
    wr(`LHG_A_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1 check("irq on", irq_q, 32'h1);
    wr(`LHG_A_IRQ_STS, 32'h1);
    repeat (2) @(posedge clk);
    #1 check("irq off", irq_q, 32'h0);
    rc("irq w1c", `LHG_A_IRQ_STS, 32'h6);
    wr(`LHG_A_IRQ_STS, 32'h7);
    wr(`LHG_A_IRQ_MASK, 32'h0);
    wr(`LHG_A_ALARM, 32'h50);
    steps(1);
    outs("alarm clear", 3'b000);
    $display("t_pulsed done");
  endtask
  task automatic t_latched;
    wr(`LHG_A_CTRL, 32'h2);
    wr(`LHG_A_UNLOCK, 32'h14);
    wr(`LHG_A_TRIP, 32'h14);
    steps(1);
    outs("latched trip", 3'b110);
    wr(`LHG_A_TRIP, 32'hC8);
    steps(1);
    outs("latch holds", 3'b110);
    wr(`LHG_A_UNLOCK, 32'h1E);
    steps(1);
    outs("latch clear", 3'b000);
    $display("t_latched done");
  endtask
  task automatic t_quiet;
    wr(`LHG_A_UNLOCK, 32'h14);
    wr(`LHG_A_TRIP, 32'h14);
    steps(1);
    @(posedge clk);
    blk_req <= 1'b1;
    repeat (3) @(posedge clk);
    #1 outs("blocked", 3'b000);
    blk_req <= 1'b0;
    steps(1);
    outs("unblocked", 3'b110);
    wr(`LHG_A_CTRL, 32'h0);
    steps(1);
    outs("off", 3'b000);
    wr(`LHG_A_CTRL, 32'h1);
    wr(`LHG_A_TRIP, 32'h64);
    wr(`LHG_A_UNLOCK, 32'h3C);
    $display("t_quiet done");
  endtask
  task automatic t_heat;
    logic [31:0] h0;
    logic [31:0] h1;
    logic [31:0] h2;
    wr(`LHG_A_TCONST, 32'h1);
    rd(`LHG_A_HEAT, h0);
    check("heat start", h0, 32'h0);
    @(posedge clk);
    amp       <= 16'h4000;
    phase_sel <= 2'h2;
    steps(2);
    rd(`LHG_A_HEAT, h1);
    check("heat rises", {31'h0, h1 > h0}, 32'h1);
    steps(2);
    rd(`LHG_A_HEAT, h2);
    check("heat keeps rising", {31'h0, h2 > h1}, 32'h1);
    amp <= 16'h0000;
    $display("t_heat done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    clk            = 1'b0;
    rst_n          = 1'b0;
    amp            = 16'h0000;
    phase_sel      = 2'h0;
    blk_req        = 1'b0;
    hr_req         = 1'b0;
    ambient_sensor = 8'h28;
    addr           = 8'h00;
    wdata          = 32'h0;
    wr_en          = 1'b0;
    rd_en          = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_ambient;
    t_startup;
    t_pulsed;
    t_latched;
    t_quiet;
    t_heat;
    finish_test;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test;
  end

endmodule

`default_nettype wire
